// *** rtl/eew_pkg.sv ***
// Shared constants and types of the two-wire serial EEPROM slave engine.
// Assumes a 100 MHz system clock and an 8-bit wide, 2048-deep array.
package eew_pkg;

  // System clock rate
  localparam int unsigned CLK_FREQ_HZ  = 100_000_000;
  // Longest self-timed programming time
  localparam int unsigned PROG_TIME_MS = 5;
  localparam int unsigned PROG_CYCLES  = PROG_TIME_MS * (CLK_FREQ_HZ / 1000);

  // Array and page geometry
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned PAGE_IDX_W = 4;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned ARRAY_DEPTH = 2048;

  // Control byte field positions
  localparam int unsigned CTRL_ID_LSB   = 4;
  localparam int unsigned CTRL_BLK_LSB  = 1;
  localparam int unsigned CTRL_RW_BIT   = 0;

  // Device-type identifier; value is arbitrary
  localparam logic [3:0] DEV_TYPE_ID = 4'h6;

  // Bit counts within one byte slot
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_END = 4'h9;

  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;

  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR,
    ST_DATA,
    ST_READ,
    ST_PROG
  } eew_state_t;

endpackage

// *** rtl/eew_mem.sv ***
// Simple memory with one write port and one registered read port.
// Assumes both ports on one clock; no reset of the contents.
`timescale 1ns/100ps
module eew_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = 4
) (
  input  wire logic             clk_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Write and registered read
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule // eew_mem

// *** rtl/eew_engine.sv ***
// Two-wire slave command engine of a 2048-byte serial EEPROM.
// Assumes open-drain bus lines resolved outside; pins are asynchronous to ref_clk_i.
//
// Functional notes
// - Every command begins with start: data falls while clock high.
// - All bus activity is ignored until a start condition is seen.
// - Every transfer ends with stop: data rises while clock high.
// - A write not closed by stop leaves the array unchanged.
// - Upper four control bits must match the device-type identifier.
// - In write commands the next three control bits select a 256-byte block, address MSBs; reads ignore them.
// - Control bit zero: one reads, zero writes or sets the address.
// - Write-protect high refuses writes everywhere; reads work at either level.
// - Receiver pulls data low on the ninth clock to acknowledge.
// - Device acknowledges a control byte addressed to it after start.
// - In writes with write-protect low every byte after the control byte is acknowledged.
// - Reads send eight bits, release, then sample the master acknowledge.
// - Low acknowledge sends next byte; high ends output until stop.
// - Byte write programs only once the stop condition arrives.
// - Page write: only four low address bits increment, upper seven fixed.
// - Beyond sixteen bytes the index wraps and overwrites buffered bytes.
// - After reads the counter points one past the last byte read.
// - After writes the counter keeps the last written address.
// - Sequential reads run through the whole array while acknowledged.
// - Random read: write-direction address phase, then a read command.
// - Write-protect is ignored until the first data bit rising edge.
// - Later write-protect high cancels the write and returns to standby.
// - Data is sampled on clock rise and changed after clock fall.
// - During programming all commands are ignored without acknowledge.
// - Start followed by stop during command input cancels the command.
`timescale 1ns/100ps
module eew_engine #(
  parameter int unsigned PROG_CYCLES = eew_pkg::PROG_CYCLES,
  parameter logic [3:0]  DEV_ID      = eew_pkg::DEV_TYPE_ID
) (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic wp_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  output logic      prog_busy_o
);

  localparam int unsigned TMR_W = $clog2(PROG_CYCLES + 1);
  localparam int unsigned AW    = eew_pkg::ADDR_W;
  localparam int unsigned PW    = eew_pkg::PAGE_IDX_W;

  typedef struct packed {
    logic [2:0]          scl_s;
    logic [2:0]          sda_s;
    logic [2:0]          wp_s;
    logic                scl_v;
    logic                sda_v;
    logic                wp_v;
    eew_pkg::eew_state_t state;
    logic [3:0]          cnt;
    logic [7:0]          shift;
    logic [7:0]          tx;
    logic                rw;
    logic                oe;
    logic                drv_lvl;
    logic [AW-1:0]       addr;
    logic [PW-1:0]       widx;
    logic [15:0]         mask;
    logic [PW:0]         pidx;
    logic                pwr;
    logic [PW-1:0]       pwidx;
    logic [TMR_W-1:0]    timer;
    logic                busy;
  } eew_regs_t;

  eew_regs_t q;
  eew_regs_t d;
  logic          scl_n;
  logic          sda_n;
  logic          wp_n;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_det;
  logic          stop_det;
  logic [7:0]    arr_rdata;
  logic [7:0]    buf_rdata;
  logic          arr_we;
  logic          buf_we;
  // Filtered line levels: change once second and third stage agree
  assign scl_n = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[2] : q.scl_v;
  assign sda_n = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_v;
  assign wp_n  = (q.wp_s[1] == q.wp_s[2]) ? q.wp_s[2] : q.wp_v;
  // Clock edges and bus conditions
  assign scl_rise  = scl_n & ~q.scl_v;
  assign scl_fall  = ~scl_n & q.scl_v;
  assign start_det = q.scl_v & scl_n & q.sda_v & ~sda_n;
  assign stop_det  = q.scl_v & scl_n & ~q.sda_v & sda_n;
  // Buffer each acknowledged data byte at the page index
  assign buf_we = scl_fall && (q.cnt == eew_pkg::CNT_ACK) && (q.state == eew_pkg::ST_DATA);
  // Array is written only while programming and only for loaded bytes
  assign arr_we = q.pwr && q.mask[q.pwidx] && (q.state == eew_pkg::ST_PROG);
  // Page buffer
  eew_mem #(
    .WIDTH (eew_pkg::BYTE_W),
    .DEPTH (eew_pkg::PAGE_BYTES),
    .AW    (PW)
  ) u_page_buf (
    .clk_i   (ref_clk_i),
    .we_i    (buf_we),
    .waddr_i (q.widx),
    .wdata_i (q.shift),
    .raddr_i (q.pidx[PW-1:0]),
    .rdata_o (buf_rdata)
  );
  // Nonvolatile array
  eew_mem #(
    .WIDTH (eew_pkg::BYTE_W),
    .DEPTH (eew_pkg::ARRAY_DEPTH),
    .AW    (AW)
  ) u_array (
    .clk_i   (ref_clk_i),
    .we_i    (arr_we),
    .waddr_i ({q.addr[AW-1:PW], q.pwidx}),
    .wdata_i (buf_rdata),
    .raddr_i (q.addr),
    .rdata_o (arr_rdata)
  );
  // Next-state logic of the whole engine
  always_comb begin
    d         = q;
    d.scl_s   = {q.scl_s[1:0], scl_i};
    d.sda_s   = {q.sda_s[1:0], sda_i};
    d.wp_s    = {q.wp_s[1:0], wp_i};
    d.scl_v   = scl_n;
    d.sda_v   = sda_n;
    d.wp_v    = wp_n;
    d.pwr     = 1'b0;
    d.drv_lvl = 1'b0;
    case (q.state)
      eew_pkg::ST_IDLE: begin
        d.oe = 1'b0;
      end
      eew_pkg::ST_CTRL, eew_pkg::ST_ADDR, eew_pkg::ST_DATA: begin
        if (scl_rise) begin
          if (q.cnt < eew_pkg::CNT_ACK) begin
            d.shift = {q.shift[6:0], sda_n};
          end
          d.cnt = q.cnt + 4'h1;
        end
        if (scl_fall && q.cnt == eew_pkg::CNT_ACK) begin
          case (q.state)
            eew_pkg::ST_CTRL: begin
              if (q.shift[7:eew_pkg::CTRL_ID_LSB] == DEV_ID) begin
                d.oe = 1'b1;
                d.rw = q.shift[eew_pkg::CTRL_RW_BIT];
                if (!q.shift[eew_pkg::CTRL_RW_BIT]) begin
                  d.addr[AW-1:8] = q.shift[3:eew_pkg::CTRL_BLK_LSB];
                end
              end else begin
                d.state = eew_pkg::ST_IDLE;
              end
            end
            eew_pkg::ST_ADDR: begin
              d.oe        = 1'b1;
              d.addr[7:0] = q.shift;
              d.widx      = q.shift[PW-1:0];
            end
            default: begin
              d.oe = 1'b1;
              d.mask[q.widx] = 1'b1;
              d.addr[PW-1:0] = q.widx;
              d.widx = q.widx + 4'h1;
            end
          endcase
        end
        if (scl_fall && q.cnt == eew_pkg::CNT_END) begin
          d.oe  = 1'b0;
          d.cnt = 4'h0;
          case (q.state)
            eew_pkg::ST_CTRL: begin
              if (q.rw) begin
                d.state = eew_pkg::ST_READ;
                d.tx    = arr_rdata;
                d.oe    = ~arr_rdata[7];
                d.addr  = q.addr + 11'h001;
              end else begin
                d.state = eew_pkg::ST_ADDR;
              end
            end
            eew_pkg::ST_ADDR: begin
              d.state = eew_pkg::ST_DATA;
            end
            default: begin
              d.state = q.state;
            end
          endcase
        end
        if (q.state == eew_pkg::ST_DATA && wp_n &&
            (scl_rise || q.cnt != 4'h0 || q.mask != 16'h0000)) begin
          d.state = eew_pkg::ST_IDLE;
          d.mask  = 16'h0000;
          d.oe    = 1'b0;
        end
      end
      eew_pkg::ST_READ: begin
        if (scl_rise) begin
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == eew_pkg::CNT_ACK) begin
            d.shift[0] = sda_n;
          end
        end
        if (scl_fall) begin
          if (q.cnt == eew_pkg::CNT_ACK) begin
            d.oe = 1'b0;
          end else if (q.cnt == eew_pkg::CNT_END) begin
            d.cnt = 4'h0;
            if (!q.shift[0]) begin
              d.tx   = arr_rdata;
              d.oe   = ~arr_rdata[7];
              d.addr = q.addr + 11'h001;
            end else begin
              d.state = eew_pkg::ST_IDLE;
              d.oe    = 1'b0;
            end
          end else begin
            d.tx = {q.tx[6:0], 1'b0};
            d.oe = ~q.tx[6];
          end
        end
      end
      eew_pkg::ST_PROG: begin
        d.oe    = 1'b0;
        d.timer = q.timer + 1'b1;
        if (q.pidx < 5'(eew_pkg::PAGE_BYTES)) begin
          d.pidx  = q.pidx + 5'h01;
          d.pwr   = 1'b1;
          d.pwidx = q.pidx[PW-1:0];
        end
        if (q.timer == TMR_W'(PROG_CYCLES - 1)) begin
          d.state = eew_pkg::ST_IDLE;
          d.mask  = 16'h0000;
        end
        if (wp_n) begin
          d.state = eew_pkg::ST_IDLE;
          d.mask  = 16'h0000;
        end
      end
      default: begin
        d.state = eew_pkg::ST_IDLE;
      end
    endcase
    if (q.state != eew_pkg::ST_PROG) begin
      if (stop_det) begin
        if (q.state == eew_pkg::ST_DATA && q.mask != 16'h0000 && !wp_n) begin
          d.state = eew_pkg::ST_PROG;
          d.timer = '0;
          d.pidx  = '0;
        end else begin
          d.state = eew_pkg::ST_IDLE;
          d.mask  = 16'h0000;
        end
        d.oe = 1'b0;
      end else if (start_det) begin
        d.state = eew_pkg::ST_CTRL;
        d.cnt   = 4'h0;
        d.oe    = 1'b0;
        d.mask  = 16'h0000;
      end
    end
    d.busy = (d.state == eew_pkg::ST_PROG);
  end
  // State register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      q       <= '0;
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
      q.scl_v <= 1'b1;
      q.sda_v <= 1'b1;
      q.addr  <= eew_pkg::ADDR_RST;
    end else begin
      q <= d;
    end
  end
  // Outputs straight from the state register
  assign sda_o       = q.drv_lvl;
  assign sda_oe_o    = q.oe;
  assign prog_busy_o = q.busy;
  // Start moves engine to control phase
  start_ctrl_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (start_det && !stop_det && q.state != eew_pkg::ST_PROG) |=> (q.state == eew_pkg::ST_CTRL))
    else $error("start did not enter control phase");
  // Idle never drives the line
  idle_quiet_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (q.state == eew_pkg::ST_IDLE) |-> !sda_oe_o)
    else $error("line driven while idle");
  // Stop after buffered data starts programming
  stop_prog_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (stop_det && q.state == eew_pkg::ST_DATA && q.mask != 16'h0000 && !wp_n)
    |=> (prog_busy_o && q.timer == '0))
    else $error("stop did not start programming");
  // Wrong identifier gets no acknowledge
  id_nack_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (scl_fall && q.cnt == eew_pkg::CNT_ACK && q.state == eew_pkg::ST_CTRL &&
     q.shift[7:4] != DEV_ID && !start_det && !stop_det)
    |=> (!sda_oe_o && q.state == eew_pkg::ST_IDLE))
    else $error("mismatching identifier acknowledged");
  // Write bytes are acknowledged
  write_ack_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (scl_fall && q.cnt == eew_pkg::CNT_ACK && !wp_n && !start_det && !stop_det &&
     (q.state == eew_pkg::ST_ADDR || q.state == eew_pkg::ST_DATA)) |=> sda_oe_o)
    else $error("write byte not acknowledged");
  // Protect during programming cancels at once
  prog_cancel_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (q.state == eew_pkg::ST_PROG && wp_n) |=> (!prog_busy_o && q.mask == 16'h0000))
    else $error("programming not cancelled by protect");
  // Programming stays silent and bounded
  prog_silent_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    prog_busy_o |-> (!sda_oe_o && q.timer < TMR_W'(PROG_CYCLES)))
    else $error("programming drove line or overran");
  // Page bits stay fixed while data arrives
  page_fixed_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (q.state == eew_pkg::ST_DATA && $past(q.state) == eew_pkg::ST_DATA)
    |-> (q.addr[AW-1:PW] == $past(q.addr[AW-1:PW])))
    else $error("upper address changed during page write");
  // Read releases the line for the master acknowledge
  read_release_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (q.state == eew_pkg::ST_READ && scl_fall && q.cnt == eew_pkg::CNT_ACK && !stop_det)
    |=> !sda_oe_o ##1 (q.cnt != eew_pkg::CNT_ACK || !sda_oe_o))
    else $error("line not released for acknowledge");
  // Each read byte load advances the counter by one
  read_advance_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (q.state == eew_pkg::ST_READ && scl_fall && q.cnt == eew_pkg::CNT_END && !q.shift[0] &&
     !start_det && !stop_det) |=> (q.addr == $past(q.addr) + 11'h001))
    else $error("address not advanced after read byte");
endmodule // eew_engine

// *** testbench/eew_master.sv ***
// Two-wire bus master model that drives the engine's clock and data pins.
// Assumes a pull-up resolves sda outside; steps on the link clock, idles with scl high.
`timescale 1ns/100ps
module eew_master (
  input  wire logic lclk_i,
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  // Quarter bit time, ends on a falling reference edge
  task automatic tk();
    repeat (4) @(posedge lclk_i);
    @(negedge ref_clk_i);
  endtask

  task automatic start();
    sda_oe_o = 1'b0;
    tk();
    scl_o = 1'b1;
    tk();
    sda_oe_o = 1'b1;
    tk();
    scl_o = 1'b0;
    tk();
  endtask

  task automatic stop();
    sda_oe_o = 1'b1;
    tk();
    scl_o = 1'b1;
    tk();
    sda_oe_o = 1'b0;
    tk();
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_oe_o = ~b;
    tk();
    scl_o = 1'b1;
    tk();
    r = sda_i;
    tk();
    scl_o = 1'b0;
    tk();
  endtask

  task automatic tx(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask

  task automatic sw_reset();
    logic r;
    start();
    repeat (9) bit_io(1'b1, r);
    start();
  endtask
endmodule // eew_master

// *** testbench/eew_engine_tb_top.sv ***
// Self-checking bench of the two-wire EEPROM engine with a bus master model.
// Assumes the engine's own assertions watch its internals.
`timescale 1ns/100ps
module eew_engine_tb_top;
  localparam int unsigned PROG = 2000;
  logic        ref_clk = 1'b0;
  logic        lclk    = 1'b0;
  logic        reset   = 1'b1;
  logic        wp      = 1'b0;
  logic        scl;
  logic        m_oe;
  logic        d_oe;
  logic        d_o;
  logic        busy;
  wire logic   sda;
  logic [7:0]  exp_mem [2048];
  logic [10:0] cnt;
  int          fails = 0;
  int          n_compared = 0;
  int          busy_run = 0;
  int          busy_len = 0;

  // Pull-up with wired-AND of both drivers
  assign sda = ~(m_oe | d_oe);
  always #5 ref_clk = ~ref_clk;
  // Length of the last programming run in reference cycles
  always @(negedge ref_clk) begin
    if (busy === 1'b1) begin
      busy_run <= busy_run + 1;
    end else begin
      if (busy_run != 0) begin
        busy_len <= busy_run;
      end
      busy_run <= 0;
    end
  end
  // Link clock, offset in phase
  initial begin
    #3;
    forever #16 lclk = ~lclk;
  end

  eew_engine #(.PROG_CYCLES(PROG)) eew_engine_i (
    .ref_clk_i(ref_clk), .reset_i(reset), .scl_i(scl), .sda_i(sda), .wp_i(wp),
    .sda_o(d_o), .sda_oe_o(d_oe), .prog_busy_o(busy));
  eew_master eew_master_i (
    .lclk_i(lclk), .ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Bounded wait for the programming flag
  task automatic wait_busy(input logic lv);
    for (int i = 0; i < PROG + 100 && busy !== lv; i++) @(negedge ref_clk);
    if (busy !== lv) begin
      fails++;
      $display("wrong value busy wait expected %h seen %h", lv, busy);
      report_and_stop();
    end
  endtask

  task automatic prog_chk(input logic ok);
    if (ok) begin
      wait_busy(1'b1);
      wait_busy(1'b0);
      @(negedge ref_clk);
      chk("prog length", 16'(PROG), busy_len[15:0]); // length
    end else begin
      repeat (20) @(negedge ref_clk);
      chk("no prog", 16'h0000, busy); // nothing starts
    end
  endtask

  // Mode 0 plain, 1 wp during address, 2 wp after data, 3 no stop
  task automatic wr(input logic [2:0] b, input logic [7:0] a, input int n,
                    input logic [7:0] d0, input int mode);
    logic        ak;
    logic [10:0] ad;
    eew_master_i.start();
    eew_master_i.tx({eew_pkg::DEV_TYPE_ID, b, 1'b0}, ak); // write
    chk("ctrl ack", 16'h0001, ak); // ack
    if (mode == 1) wp = 1'b1;
    eew_master_i.tx(a, ak); // word address
    wp = 1'b0;
    chk("addr ack", 16'h0001, ak); // ack
    for (int i = 0; i < n; i++) begin
      eew_master_i.tx(d0 + i[7:0], ak);
      chk("data ack", 16'h0001, ak); // ack
      ad = {b, a[7:4], a[3:0] + i[3:0]}; // page wrap
      if (mode < 2) begin
        exp_mem[ad] = d0 + i[7:0];
        cnt = ad;
      end
    end
    chk("early prog", 16'h0000, busy); // waits for stop
    if (mode == 2) wp = 1'b1;
    if (mode != 3) eew_master_i.stop();
  endtask

  task automatic rd(input logic rnd, input logic [2:0] b, input logic [7:0] a, input int n);
    logic       ak;
    logic [7:0] d;
    if (rnd) begin
      eew_master_i.start();
      eew_master_i.tx({eew_pkg::DEV_TYPE_ID, b, 1'b0}, ak); // address phase
      eew_master_i.tx(a, ak);
      cnt = {b, a};
    end
    eew_master_i.start();
    eew_master_i.tx({eew_pkg::DEV_TYPE_ID, b, 1'b1}, ak);
    chk("read ctrl ack", 16'h0001, ak); // ack
    for (int i = 0; i < n; i++) begin
      eew_master_i.rx(i == n - 1, d);
      chk("read data", exp_mem[cnt], d); // data order
      cnt++;
    end
    chk("released after nack", 16'h0000, d_oe); // output ends
    chk("drive level", 16'h0000, d_o); // open drain pulls low
    eew_master_i.stop();
  endtask

  task automatic t_basic();
    logic       ak;
    logic [7:0] d;
    wr(3'h0, 8'hff, 1, 8'h3c, 0);
    prog_chk(1'b1);
    wr(3'h1, 8'h00, 1, 8'ha5, 0);
    prog_chk(1'b1);
    rd(1'b0, 3'h0, 8'h00, 1); // last written
    rd(1'b1, 3'h0, 8'hff, 2); // crosses block
    eew_master_i.start();
    eew_master_i.tx({~eew_pkg::DEV_TYPE_ID, 3'h0, 1'b1}, ak);
    chk("foreign id ack", 16'h0000, ak); // no ack
    eew_master_i.rx(1'b1, d);
    chk("foreign id data", 16'h00ff, d); // line released
    eew_master_i.stop();
    $display("test basic done");
  endtask

  task automatic t_page();
    wr(3'h1, 8'h1e, 18, 8'h40, 0); // overwrite
    prog_chk(1'b1);
    rd(1'b1, 3'h1, 8'h10, 15);
    rd(1'b0, 3'h1, 8'h00, 1); // next byte
    $display("test page done");
  endtask

  task automatic t_poll();
    logic ak;
    wr(3'h2, 8'h10, 1, 8'h66, 0);
    wait_busy(1'b1);
    eew_master_i.start();
    eew_master_i.tx({eew_pkg::DEV_TYPE_ID, 3'h2, 1'b0}, ak);
    chk("busy ack", 16'h0000, ak); // ignored
    eew_master_i.stop();
    wait_busy(1'b0);
    rd(1'b1, 3'h2, 8'h10, 1); // ack after programming
    $display("test poll done");
  endtask

  task automatic t_wp();
    wr(3'h2, 8'h20, 1, 8'h11, 1); // early wp ignored
    prog_chk(1'b1);
    wr(3'h3, 8'h30, 1, 8'h77, 0);
    wait_busy(1'b1);
    wp = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk("wp prog cancel", 16'h0000, busy); // standby at once
    wp = 1'b0;
    repeat (8) @(negedge ref_clk);
    wr(3'h2, 8'h20, 1, 8'h99, 2); // cancelled
    prog_chk(1'b0);
    rd(1'b1, 3'h2, 8'h20, 1); // read under wp
    wp = 1'b0;
    $display("test wp done");
  endtask

  task automatic t_abort();
    wr(3'h2, 8'h20, 1, 8'h5a, 3); // no stop
    eew_master_i.sw_reset();
    eew_master_i.stop();
    prog_chk(1'b0); // discarded
    eew_master_i.start();
    eew_master_i.stop();
    prog_chk(1'b0); // cancel
    rd(1'b1, 3'h2, 8'h20, 1); // old data kept
    $display("test abort done");
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_basic();
    t_page();
    t_poll();
    t_wp();
    t_abort();
    report_and_stop();
  end
endmodule // eew_engine_tb_top
